// ### nsx_datapath.sv
// datapath for nibble swap, exclusive or, and direction load operations
// Contract
// - nibble swap puts file bits 3:0 into result 7:4 and bits 7:4 into 3:0, flags unchanged.
// - destination bit 0 sends the result to the working register, 1 back to the file register.
// - literal xor puts working register xor 8-bit literal into the working register, zero only.
// - file xor of working register and file register 0..127 goes by destination, zero only.
// - direction load copies working register to port a, b or c direction for 5, 6 or 7.
`timescale 1ns/1ps
module nsx_datapath
	import nsx_pkg::*;
(
	// clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RSTN,
	// operation issue
	input  wire logic              OP_VALID,
	input  wire logic [OP_W-1:0]   OP_CODE,
	input  wire logic [ADDR_W-1:0] FILE_ADDR,
	input  wire logic              DEST_BIT,
	input  wire logic [DATA_W-1:0] LITERAL,
	input  wire logic [DATA_W-1:0] FILE_RDATA,
	// file register write back
	output logic                   FILE_WE,
	output logic      [ADDR_W-1:0] FILE_WADDR,
	output logic      [DATA_W-1:0] FILE_WDATA,
	// architectural state
	output logic      [DATA_W-1:0] W_OUT,
	output logic                   ZERO_FLAG,
	output logic      [DATA_W-1:0] PORT_A_DIRECTION,
	output logic      [DATA_W-1:0] PORT_B_DIRECTION,
	output logic      [DATA_W-1:0] PORT_C_DIRECTION
);
	logic [DATA_W-1:0] w_reg;
	logic              zero_reg;
	logic [DATA_W-1:0] dir_reg [3];
	logic [DATA_W-1:0] result_next;
	logic              to_file_next;
	logic              to_w_next;
	logic              zero_upd_next;
	logic [1:0]        dir_idx_next;
	logic              dir_we_next;
	logic              fwe_reg;
	logic [ADDR_W-1:0] fwaddr_reg;
	logic [DATA_W-1:0] fwdata_reg;

	// operation decode and result
	always_comb
	begin
		result_next   = ZERO_BYTE;
		to_file_next  = 1'b0;
		to_w_next     = 1'b0;
		zero_upd_next = 1'b0;
		dir_we_next   = 1'b0;
		dir_idx_next  = 2'h0;
		if (OP_VALID)
		begin
			case (nsx_op_t'(OP_CODE))
				NIBBLE_SWAP_OP:
				begin
					result_next  = {FILE_RDATA[NIB_LO +: NIB_W],
						FILE_RDATA[NIB_HI +: NIB_W]};
					to_file_next = DEST_BIT;
					to_w_next    = !DEST_BIT;
				end
				XOR_LITERAL_OP:
				begin
					result_next   = w_reg ^ LITERAL;
					to_w_next     = 1'b1;
					zero_upd_next = 1'b1;
				end
				XOR_FILE_OP:
				begin
					result_next   = w_reg ^ FILE_RDATA;
					to_file_next  = DEST_BIT;
					to_w_next     = !DEST_BIT;
					zero_upd_next = 1'b1;
				end
				DIRECTION_LOAD_OP:
				begin
					result_next = w_reg;
					case (FILE_ADDR)
						DIR_SEL_A:
						begin
							dir_we_next  = 1'b1;
							dir_idx_next = 2'h0;
						end
						DIR_SEL_B:
						begin
							dir_we_next  = 1'b1;
							dir_idx_next = 2'h1;
						end
						DIR_SEL_C:
						begin
							dir_we_next  = 1'b1;
							dir_idx_next = 2'h2;
						end
						default:
						begin
							dir_we_next  = 1'b0;
							dir_idx_next = 2'h0;
						end
					endcase
				end
				default:
				begin
					result_next = ZERO_BYTE;
				end
			endcase
		end
	end

	// working register
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
			w_reg <= W_RESET;
		else if (to_w_next)
			w_reg <= result_next;
	end

	// zero flag
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
			zero_reg <= 1'b0;
		else if (zero_upd_next)
			zero_reg <= (result_next == ZERO_BYTE);
	end

	// direction registers
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_dir
			always_ff @(posedge CLOCK or negedge RSTN)
			begin
				if (!RSTN)
					dir_reg[gi] <= DIR_RESET;
				else if (dir_we_next && dir_idx_next == 2'(gi))
					dir_reg[gi] <= w_reg;
			end
		end
	endgenerate

	// file write back
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			fwe_reg    <= 1'b0;
			fwaddr_reg <= '0;
			fwdata_reg <= ZERO_BYTE;
		end
		else
		begin
			fwe_reg <= to_file_next;
			if (to_file_next)
			begin
				fwaddr_reg <= FILE_ADDR;
				fwdata_reg <= result_next;
			end
		end
	end

	assign W_OUT            = w_reg;
	assign ZERO_FLAG        = zero_reg;
	assign PORT_A_DIRECTION = dir_reg[0];
	assign PORT_B_DIRECTION = dir_reg[1];
	assign PORT_C_DIRECTION = dir_reg[2];
	assign FILE_WE          = fwe_reg;
	assign FILE_WADDR       = fwaddr_reg;
	assign FILE_WDATA       = fwdata_reg;

	// checks
	swap_result_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == NIBBLE_SWAP_OP && DEST_BIT |=>
		FILE_WE && FILE_WDATA == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
		else $error("nibble swap result wrong");
	swap_flag_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == NIBBLE_SWAP_OP |=> $stable(ZERO_FLAG))
		else $error("nibble swap changed zero flag");
	dest_w_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == NIBBLE_SWAP_OP && !DEST_BIT |=>
		!FILE_WE && W_OUT == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
		else $error("destination zero not to working register");
	xorl_result_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_LITERAL_OP |=>
		!FILE_WE && W_OUT == ($past(W_OUT) ^ $past(LITERAL)))
		else $error("literal xor result wrong");
	xorf_file_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_FILE_OP && DEST_BIT |=>
		FILE_WE && FILE_WADDR == $past(FILE_ADDR) && $stable(W_OUT)
		&& FILE_WDATA == ($past(W_OUT) ^ $past(FILE_RDATA)))
		else $error("file xor write back wrong");
	dir_load_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == DIRECTION_LOAD_OP && FILE_ADDR == DIR_SEL_B |=>
		PORT_B_DIRECTION == $past(W_OUT) && $stable(PORT_A_DIRECTION)
		&& $stable(PORT_C_DIRECTION) && $stable(ZERO_FLAG))
		else $error("direction load wrong");
	zero_set_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && (OP_CODE == XOR_LITERAL_OP || OP_CODE == XOR_FILE_OP) |=>
		ZERO_FLAG == (($past(OP_CODE) == XOR_LITERAL_OP ?
		$past(W_OUT) ^ $past(LITERAL) : $past(W_OUT) ^ $past(FILE_RDATA)) == 8'h00))
		else $error("zero flag wrong");
	idle_quiet_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!OP_VALID |=> !FILE_WE && $stable(W_OUT) && $stable(ZERO_FLAG))
		else $error("state changed without operation");

	// per operation side effects, idle stability and the source of each state change
	swap_keep_w_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == NIBBLE_SWAP_OP && DEST_BIT |=> $stable(W_OUT)
		&& FILE_WADDR == $past(FILE_ADDR))
		else $error("nibble swap to file changed working register");
	swap_dirs_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == NIBBLE_SWAP_OP |=> $stable(PORT_A_DIRECTION)
		&& $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
		else $error("nibble swap changed a direction register");
	swap_w_file_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == NIBBLE_SWAP_OP && !DEST_BIT |=>
		$stable(FILE_WADDR) && $stable(FILE_WDATA))
		else $error("nibble swap to working register touched write back");
	xorl_no_file_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_LITERAL_OP |=>
		$stable(FILE_WADDR) && $stable(FILE_WDATA))
		else $error("literal xor touched write back");
	xorl_dirs_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_LITERAL_OP |=> $stable(PORT_A_DIRECTION)
		&& $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
		else $error("literal xor changed a direction register");
	xorl_zero_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_LITERAL_OP |=>
		ZERO_FLAG == (W_OUT == ZERO_BYTE))
		else $error("literal xor zero flag wrong");
	xorf_w_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_FILE_OP && !DEST_BIT |=>
		!FILE_WE && W_OUT == ($past(W_OUT) ^ $past(FILE_RDATA)))
		else $error("file xor to working register wrong");
	xorf_w_zero_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_FILE_OP && !DEST_BIT |=>
		ZERO_FLAG == (W_OUT == ZERO_BYTE))
		else $error("file xor zero flag wrong for working register");
	xorf_f_zero_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_FILE_OP && DEST_BIT |=>
		ZERO_FLAG == (FILE_WDATA == ZERO_BYTE))
		else $error("file xor zero flag wrong for file register");
	xorf_dirs_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_FILE_OP |=> $stable(PORT_A_DIRECTION)
		&& $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
		else $error("file xor changed a direction register");
	xorf_keep_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == XOR_FILE_OP && !DEST_BIT |=>
		$stable(FILE_WADDR) && $stable(FILE_WDATA))
		else $error("file xor to working register touched write back");
	dir_a_load_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == DIRECTION_LOAD_OP && FILE_ADDR == DIR_SEL_A |=>
		PORT_A_DIRECTION == $past(W_OUT) && $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
		else $error("port a direction load wrong");
	dir_c_load_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == DIRECTION_LOAD_OP && FILE_ADDR == DIR_SEL_C |=>
		PORT_C_DIRECTION == $past(W_OUT) && $stable(PORT_A_DIRECTION) && $stable(PORT_B_DIRECTION))
		else $error("port c direction load wrong");
	dir_refuse_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == DIRECTION_LOAD_OP && FILE_ADDR != DIR_SEL_A && FILE_ADDR != DIR_SEL_B
		&& FILE_ADDR != DIR_SEL_C |=> $stable(PORT_A_DIRECTION) && $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
		else $error("direction load with bad operand changed state");
	dir_keep_w_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == DIRECTION_LOAD_OP |=>
		$stable(W_OUT) && !FILE_WE && $stable(FILE_WADDR))
		else $error("direction load touched working register or write back");
	dir_flag_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		OP_VALID && OP_CODE == DIRECTION_LOAD_OP |=>
		$stable(ZERO_FLAG))
		else $error("direction load changed zero flag");
	we_source_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		FILE_WE |-> $past(OP_VALID) && $past(DEST_BIT) && ($past(OP_CODE) == NIBBLE_SWAP_OP
		|| $past(OP_CODE) == XOR_FILE_OP))
		else $error("write back without a file destination operation");
	idle_dirs_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!OP_VALID |=> $stable(PORT_A_DIRECTION)
		&& $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
		else $error("direction changed without operation");
	idle_file_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!OP_VALID |=>
		$stable(FILE_WADDR) && $stable(FILE_WDATA))
		else $error("write back changed without operation");
	zero_source_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!$stable(ZERO_FLAG) |-> $past(OP_VALID) && ($past(OP_CODE) == XOR_LITERAL_OP
		|| $past(OP_CODE) == XOR_FILE_OP))
		else $error("zero flag changed outside xor");
	w_source_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!$stable(W_OUT) |-> $past(OP_VALID)
		&& $past(OP_CODE) != DIRECTION_LOAD_OP)
		else $error("working register changed without a result");
	dir_a_source_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!$stable(PORT_A_DIRECTION) |-> $past(OP_VALID)
		&& $past(OP_CODE) == DIRECTION_LOAD_OP && $past(FILE_ADDR) == DIR_SEL_A)
		else $error("port a direction changed without load");
	dir_b_source_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!$stable(PORT_B_DIRECTION) |-> $past(OP_VALID)
		&& $past(OP_CODE) == DIRECTION_LOAD_OP && $past(FILE_ADDR) == DIR_SEL_B)
		else $error("port b direction changed without load");
	dir_c_source_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!$stable(PORT_C_DIRECTION) |-> $past(OP_VALID)
		&& $past(OP_CODE) == DIRECTION_LOAD_OP && $past(FILE_ADDR) == DIR_SEL_C)
		else $error("port c direction changed without load");
endmodule // nsx_datapath

// ### nsx_datapath_tb.sv
// testbench: operation stream with queued expectations checked one cycle after issue
`timescale 1ns/1ps
module nsx_datapath_tb
	import nsx_pkg::*;
;
	logic              clock, rstn, op_valid, dest_bit, file_we, zero_flag, ez, ewe;
	logic [OP_W-1:0]   op_code;
	logic [ADDR_W-1:0] file_addr, file_waddr, ewa;
	logic [DATA_W-1:0] literal, file_rdata, file_wdata, w_out, dir_a, dir_b, dir_c;
	logic [DATA_W-1:0] ew, eda, edb, edc, ewd, r;
	logic [31:0]       seed = 32'h6d37;
	int                error_cnt = 0, n_checks = 0, ncnt = 0;
	int                qd[$];
	logic [48:0]       qe[$];

	nsx_datapath DUT (.CLOCK(clock), .RSTN(rstn), .OP_VALID(op_valid), .OP_CODE(op_code),
		.FILE_ADDR(file_addr), .DEST_BIT(dest_bit), .LITERAL(literal), .FILE_RDATA(file_rdata),
		.FILE_WE(file_we), .FILE_WADDR(file_waddr), .FILE_WDATA(file_wdata), .W_OUT(w_out),
		.ZERO_FLAG(zero_flag), .PORT_A_DIRECTION(dir_a), .PORT_B_DIRECTION(dir_b),
		.PORT_C_DIRECTION(dir_c));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [48:0] g, input logic [48:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// drive one cycle and note the expected state after it
	task automatic issue(input logic v, input nsx_op_t c, input logic [ADDR_W-1:0] a,
		input logic d, input logic [DATA_W-1:0] k, input logic [DATA_W-1:0] f);
		@(posedge clock);
		op_valid   <= v;
		op_code    <= c;
		file_addr  <= a;
		dest_bit   <= d;
		literal    <= k;
		file_rdata <= f;
		ewe = 1'b0;
		if (v)
		begin
			r = (c == NIBBLE_SWAP_OP) ? {f[3:0], f[7:4]} :
				ew ^ ((c == XOR_LITERAL_OP) ? k : f);
			if (c == XOR_LITERAL_OP || c == XOR_FILE_OP)
				ez = (r == ZERO_BYTE);
			if (c == DIRECTION_LOAD_OP)
			begin
				if (a == DIR_SEL_A) eda = ew;
				if (a == DIR_SEL_B) edb = ew;
				if (a == DIR_SEL_C) edc = ew;
			end
			else if (d && c != XOR_LITERAL_OP)
			begin
				ewe = 1'b1;
				ewa = a;
				ewd = r;
			end
			else
				ew = r;
		end
		qd.push_back(ncnt + 2);
		qe.push_back({ewe, ewa, ewd, ew, ez, eda, edb, edc});
	endtask

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// monitor: compare each due note with the outputs
	initial
	forever
	begin
		@(negedge clock);
		ncnt++;
		while (qd.size() > 0 && qd[0] <= ncnt)
		begin
			void'(qd.pop_front());
			chk({file_we, file_waddr, file_wdata, w_out, zero_flag, dir_a, dir_b, dir_c},
				qe.pop_front());
		end
	end

	initial
	begin
		#(2000 * 25);
		error_cnt++;
		print_verdict();
	end

	initial
	begin
		{rstn, op_valid, op_code, file_addr, dest_bit, literal, file_rdata} = '0;
		{ew, ez, ewe, ewa, ewd} = '0;
		{eda, edb, edc} = {DIR_RESET, DIR_RESET, DIR_RESET};
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		issue(1'b0, NIBBLE_SWAP_OP, 7'h05, 1'b1, 8'h00, 8'h00);
		issue(1'b1, XOR_LITERAL_OP, 7'h00, 1'b1, 8'h5a, 8'h00);
		issue(1'b1, XOR_LITERAL_OP, 7'h00, 1'b0, 8'h5a, 8'h00);
		issue(1'b1, XOR_FILE_OP, 7'h7f, 1'b1, 8'h00, 8'h00);
		issue(1'b1, NIBBLE_SWAP_OP, 7'h7f, 1'b0, 8'h00, 8'h12);
		for (int i = 0; i < 400; i++)
		begin
			seed = xs(seed);
			issue(seed[31:28] != 4'h0, nsx_op_t'(seed[1:0]),
				(seed[1:0] == 2'h2) ? 7'(seed[14:12]) + 7'h04 : seed[8:2], seed[9],
				seed[15] ? ew : seed[23:16], seed[25] ? ew : seed[31:24]);
		end
		repeat (3) @(posedge clock);
		print_verdict();
	end
endmodule // nsx_datapath_tb

// ### nsx_pkg.sv
// package: operation codes, field widths, reset values and direction operands
package nsx_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int OP_W   = 2;

	typedef enum logic [1:0]
	{
		NIBBLE_SWAP_OP   = 2'h0,
		XOR_LITERAL_OP   = 2'h1,
		XOR_FILE_OP      = 2'h3,
		DIRECTION_LOAD_OP = 2'h2
	} nsx_op_t;

	localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
	localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
	localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;

	localparam logic [DATA_W-1:0] W_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam int NIB_LO = 0;
	localparam int NIB_HI = 4;
	localparam int NIB_W  = 4;
endpackage
